/* timer_clock_select.v */
// count clock select, prescaler, counter and its axi4-lite register slave
`timescale 1ns/1ps
`include "timer_clock_regs.vh"
module timer_clock_select (
    input wire clk,
    input wire reset_n,
    // axi4-lite write address
    input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // clock sources, sampled as levels
    input wire internal_oscillator,
    input wire low_speed_oscillator,
    input wire high_speed_oscillator,
    input wire external_clock_in,
    // timer side
    output wire count_clock_tick,
    output reg [15:0] counter_value,
    output wire [1:0] counter_channel_select,
    output wire counter_running
);
    wire rst_n;

    // clock control register fields
    reg [3:0] division_ratio_field_q;
    reg [1:0] clock_source_field_q;
    reg count_clock_gate_q;

    // channel control register fields
    reg [1:0] counter_channel_select_q;
    reg counter_run_bit_q;

    // write channel holding state
    reg aw_held_q;
    reg [`ADDR_WIDTH-1:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // source edge detection
    reg [3:0] source_level_q;
    wire [3:0] source_level;
    wire [3:0] source_rise;
    reg selected_tick;

    // decoded write
    wire write_fire;
    wire wr_clock_ctl;
    wire wr_channel_ctl;
    wire wr_counter;
    wire counter_clear;
    wire wr_mapped;
    wire wr_clock_low;
    wire wr_channel_low;

    // word address hits
    wire aw_hit_clock;
    wire aw_hit_channel;
    wire aw_hit_counter;
    wire ar_hit_clock;
    wire ar_hit_channel;
    wire ar_hit_counter;

    // decoded read
    wire read_fire;
    reg [31:0] read_word;
    reg read_mapped;

    // reset release
    reset_sync u_reset_sync (
        .clk(clk),
        .reset_n(reset_n),
        .reset_sync_n(rst_n)
    );

    // ------------------------------------------------------------------
    // write path: address and data taken in either order
    // ------------------------------------------------------------------

    // ready while the slot is free and no response is pending
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign write_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // capture write address
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= {`ADDR_WIDTH{1'b0}};
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (write_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // capture write data and strobes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (write_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // word address compare, the two low address bits ignored
    assign aw_hit_clock = ({aw_addr_q[`ADDR_WIDTH-1:2], 2'b00} == `CLOCK_CONTROL_ADDR);
    assign aw_hit_channel = ({aw_addr_q[`ADDR_WIDTH-1:2], 2'b00} == `CHANNEL_CONTROL_ADDR);
    assign aw_hit_counter = ({aw_addr_q[`ADDR_WIDTH-1:2], 2'b00} == `COUNTER_DATA_ADDR);

    // register decode
    assign wr_clock_ctl = write_fire && aw_hit_clock;
    assign wr_channel_ctl = write_fire && aw_hit_channel;
    assign wr_counter = write_fire && aw_hit_counter;
    assign wr_mapped = wr_clock_ctl || wr_channel_ctl || wr_counter;

    // only byte lane 0 holds fields
    assign wr_clock_low = wr_clock_ctl && w_strb_q[0];
    assign wr_channel_low = wr_channel_ctl && w_strb_q[0];

    // write response, one cycle after both halves are held
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // division ratio field of the clock control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            division_ratio_field_q <= `DIV_RESET;
        end else if (wr_clock_low) begin
            division_ratio_field_q <= w_data_q[`DIV_MSB:`DIV_LSB];
        end
    end

    // source field of the clock control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_field_q <= `SRC_RESET;
        end else if (wr_clock_low) begin
            clock_source_field_q <= w_data_q[`SRC_MSB:`SRC_LSB];
        end
    end

    // gate bit; bit 1 has no storage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_clock_gate_q <= 1'b0;
        end else if (wr_clock_low) begin
            count_clock_gate_q <= w_data_q[`GATE_BIT];
        end
    end

    // counter select field of the channel control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_channel_select_q <= `SEL_RESET;
        end else if (wr_channel_low) begin
            counter_channel_select_q <= w_data_q[`SEL_MSB:`SEL_LSB];
        end
    end

    // run bit; clear bit is a write pulse only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_run_bit_q <= 1'b0;
        end else if (wr_channel_low) begin
            counter_run_bit_q <= w_data_q[`RUN_BIT];
        end
    end

    assign counter_clear = wr_channel_low && w_data_q[`CLEAR_BIT];

    // ------------------------------------------------------------------
    // source selection and prescaler
    // ------------------------------------------------------------------

    assign source_level = {external_clock_in, high_speed_oscillator, low_speed_oscillator, internal_oscillator};

    // previous source levels for rising edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            source_level_q <= 4'h0;
        end else begin
            source_level_q <= source_level;
        end
    end

    assign source_rise = source_level & ~source_level_q;

    // pick the rising edges of the chosen source
    always @* begin
        case (clock_source_field_q)
            `SRC_INTERNAL: selected_tick = source_rise[0];
            `SRC_LOW_SPEED: selected_tick = source_rise[1];
            `SRC_HIGH_SPEED: selected_tick = source_rise[2];
            `SRC_EXTERNAL: selected_tick = source_rise[3];
            default: selected_tick = 1'b0;
        endcase
    end

    // divider with gate
    count_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .source_tick(selected_tick),
        .gate(count_clock_gate_q),
        .ratio(division_ratio_field_q),
        .count_tick_q(count_clock_tick)
    );

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------

    // clear wins over a tick in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= 16'h0000;
        end else if (counter_clear) begin
            counter_value <= 16'h0000;
        end else if (counter_run_bit_q && count_clock_tick) begin
            counter_value <= counter_value + 16'h0001;
        end
    end

    assign counter_channel_select = counter_channel_select_q;
    assign counter_running = counter_run_bit_q;

    // ------------------------------------------------------------------
    // read path: answer one cycle after the address is taken
    // ------------------------------------------------------------------

    assign s_axi_arready = !s_axi_rvalid;
    assign read_fire = s_axi_arvalid && s_axi_arready;

    // read address compare, the two low address bits ignored
    assign ar_hit_clock = ({s_axi_araddr[`ADDR_WIDTH-1:2], 2'b00} == `CLOCK_CONTROL_ADDR);
    assign ar_hit_channel = ({s_axi_araddr[`ADDR_WIDTH-1:2], 2'b00} == `CHANNEL_CONTROL_ADDR);
    assign ar_hit_counter = ({s_axi_araddr[`ADDR_WIDTH-1:2], 2'b00} == `COUNTER_DATA_ADDR);

    // read mux, reserved bits and the clear bit read zero
    always @* begin
        read_word = 32'h0000_0000;
        read_mapped = 1'b1;
        if (ar_hit_clock) begin
            read_word[`DIV_MSB:`DIV_LSB] = division_ratio_field_q;
            read_word[`SRC_MSB:`SRC_LSB] = clock_source_field_q;
            read_word[`GATE_BIT] = count_clock_gate_q;
        end else if (ar_hit_channel) begin
            read_word[`SEL_MSB:`SEL_LSB] = counter_channel_select_q;
            read_word[`RUN_BIT] = counter_run_bit_q;
        end else if (ar_hit_counter) begin
            read_word[15:0] = counter_value;
        end else begin
            read_mapped = 1'b0;
        end
    end

    // read data held until rready
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (read_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // timer_clock_select

/* timer_clock_regs.vh */
// register map, field positions, reset values and bus response codes for the count clock block
// Functional notes
// - division field bits 7..4 divides source by 1 up to 1/16384, resets to 0.
// - source field bits 3..2: 3 external, 2 high-speed, 1 low-speed, 0 internal.
// - divided count clock reaches the timer only while gate bit 0 is 1.
// - clock control is an 8-bit register, bit 1 reserved with no function.
// - counter runs while run bit is 1, halts while 0, resets to 0.
// - writing 1 to counter reset bit clears counter, 0 ignored, reads 0.
`ifndef TIMER_CLOCK_REGS_VH
`define TIMER_CLOCK_REGS_VH

// register indices; byte address is four times the index
`define CLOCK_CONTROL_INDEX 20'h0_5069
`define CHANNEL_CONTROL_INDEX 20'h0_5420
`define COUNTER_DATA_INDEX 20'h0_5422
`define CLOCK_CONTROL_ADDR 20'h1_41a4
`define CHANNEL_CONTROL_ADDR 20'h1_5080
`define COUNTER_DATA_ADDR 20'h1_5088
`define ADDR_WIDTH 20

// clock control fields
`define DIV_MSB 7
`define DIV_LSB 4
`define SRC_MSB 3
`define SRC_LSB 2
`define GATE_BIT 0
`define DIV_RESET 4'h0
`define SRC_RESET 2'h0
`define DIV_MAX 4'he
`define PRESCALE_WIDTH 14

// clock source codes
`define SRC_INTERNAL 2'h0
`define SRC_LOW_SPEED 2'h1
`define SRC_HIGH_SPEED 2'h2
`define SRC_EXTERNAL 2'h3

// channel control fields
`define SEL_MSB 5
`define SEL_LSB 4
`define CLEAR_BIT 1
`define RUN_BIT 0
`define SEL_RESET 2'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* reset_sync.v */
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module reset_sync (
    input wire clk,
    input wire reset_n,
    output wire reset_sync_n
);
    reg stage1_q;
    reg stage2_q;

    // assert at once, release after two edges
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign reset_sync_n = stage2_q;
endmodule // reset_sync

/* count_prescaler.v */
// power-of-two prescaler for the selected source ticks
`timescale 1ns/1ps
`include "timer_clock_regs.vh"
module count_prescaler (
    input wire clk,
    input wire rst_n,
    input wire source_tick,
    input wire gate,
    input wire [3:0] ratio,
    output reg count_tick_q
);
    reg [`PRESCALE_WIDTH-1:0] stage_q;
    wire [`PRESCALE_WIDTH-1:0] one_hot;
    wire [`PRESCALE_WIDTH-1:0] mask;
    wire ratio_valid;
    wire wrap;

    // ratio n from 0 to 14 gives one tick every 2**n source ticks
    assign one_hot = {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1} << ratio;
    assign mask = one_hot - {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    assign ratio_valid = (ratio <= `DIV_MAX); // code 0xf gives no tick
    assign wrap = ((stage_q & mask) == mask);

    // stage held at zero while the gate is off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= {`PRESCALE_WIDTH{1'b0}};
            count_tick_q <= 1'b0;
        end else if (!gate) begin
            stage_q <= {`PRESCALE_WIDTH{1'b0}};
            count_tick_q <= 1'b0;
        end else begin
            if (source_tick) begin
                stage_q <= stage_q + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
            end
            count_tick_q <= source_tick && ratio_valid && wrap;
        end
    end
endmodule // count_prescaler

/* timer_clock_select_chk.sv */
// assertions and covers on the count clock select block ports
`timescale 1ns/1ps
module timer_clock_select_chk (
    input wire clk,
    input wire reset_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire internal_oscillator,
    input wire low_speed_oscillator,
    input wire high_speed_oscillator,
    input wire external_clock_in,
    input wire count_clock_tick,
    input wire [15:0] counter_value,
    input wire [1:0] counter_channel_select,
    input wire counter_running
);
    // no write held, offered or answered
    wire wr_idle = s_axi_awready & s_axi_wready & !s_axi_awvalid & !s_axi_wvalid;
    wire [3:0] src = {external_clock_in, high_speed_oscillator, low_speed_oscillator, internal_oscillator};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // count path
    property p_tick_src; count_clock_tick |-> |($past(src) & ~$past(src, 2)); endproperty
    a_tick_src: assert property (p_tick_src) else $error("tick without a source edge");
    property p_tick_pulse; count_clock_tick |=> !count_clock_tick; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
    property p_cnt_inc;
        count_clock_tick && counter_running && wr_idle |=> counter_value == $past(counter_value) + 16'h1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed a tick");
    property p_cnt_hold; !counter_running && wr_idle |=> $stable(counter_value); endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("halted counter moved");
    // register fields change only with a write answer
    property p_sel_chg; $changed(counter_channel_select) |-> $rose(s_axi_bvalid); endproperty
    a_sel_chg: assert property (p_sel_chg) else $error("select changed without write");
    property p_run_chg; $changed(counter_running) |-> $rose(s_axi_bvalid); endproperty
    a_run_chg: assert property (p_run_chg) else $error("run changed without write");
    // bus answers
    property p_r_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
    a_r_hi: assert property (p_r_hi) else $error("upper read bits not zero");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while answer pending");
    c_tick: cover property (count_clock_tick && counter_running);
    c_sel3: cover property (counter_channel_select == 2'h3);
    c_wr: cover property ($rose(s_axi_bvalid));
endmodule // timer_clock_select_chk

bind timer_clock_select timer_clock_select_chk u_chk (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .internal_oscillator,
    .low_speed_oscillator, .high_speed_oscillator, .external_clock_in, .count_clock_tick,
    .counter_value, .counter_channel_select, .counter_running);

/* timer_clock_select_bench.sv */
// self-checking bench for the count clock select block
`timescale 1ns/1ps
`include "timer_clock_regs.vh"
module timer_clock_select_bench;
    reg clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg [19:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, d, v;
    reg [3:0] src;
    reg [1:0] r;
    reg [15:0] base;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, count_clock_tick, counter_running;
    wire [1:0] s_axi_bresp, s_axi_rresp, counter_channel_select;
    wire [31:0] s_axi_rdata;
    wire [15:0] counter_value;
    integer num_errors, n_compared, seed, i, s, n, k;

    timer_clock_select DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .internal_oscillator(src[0]), .low_speed_oscillator(src[1]),
        .high_speed_oscillator(src[2]), .external_clock_in(src[3]), .count_clock_tick, .counter_value,
        .counter_channel_select, .counter_running);

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // compare one value
    task chk(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bus write, each half released when taken
    task wr(input [19:0] a, input [31:0] w, output [1:0] resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask

    // bus read
    task rd(input [19:0] a, output [31:0] q, output [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        q = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // c rising edges on one source
    task pulse(input integer b, input integer c);
        repeat (c) begin
            @(posedge clk) src[b] <= 1'b1;
            @(posedge clk);
            @(posedge clk) src[b] <= 1'b0;
            @(posedge clk);
        end
    endtask

    // expected readback and count
    function [31:0] exp_clk(input [31:0] w);
        exp_clk = {24'h0, w[7:2], 1'b0, w[0]};
    endfunction
    function [31:0] exp_cnt(input [15:0] b, input integer c, input integer sh);
        exp_cnt = {16'h0, b + 16'(c >> sh)};
    endfunction

    task end_of_test;
        $display("comparisons %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        seed = 81;
        num_errors = 0;
        n_compared = 0;
        reset_n = 1'b0;
        src = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 72'h0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`CLOCK_CONTROL_ADDR, d, r);
        chk(d, 32'h0);
        rd(`CHANNEL_CONTROL_ADDR, d, r);
        chk(d, 32'h0);
        rd(20'h0, d, r);
        chk({d[29:0], r}, {30'h0, `RESP_SLVERR});
        wr(20'h0, 32'h1, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed);
            wr(`CLOCK_CONTROL_ADDR, v, r);
            chk({30'h0, r}, {30'h0, `RESP_OKAY});
            rd(`CLOCK_CONTROL_ADDR, d, r);
            chk({30'h0, r}, {30'h0, `RESP_OKAY});
            chk(d, exp_clk(v));
            wr(`CHANNEL_CONTROL_ADDR, i << 4, r);
            chk({30'h0, counter_channel_select}, i);
        end
        wr(`CHANNEL_CONTROL_ADDR, 32'h3, r);
        rd(`CHANNEL_CONTROL_ADDR, d, r);
        chk(d, 32'h1);
        chk({16'h0, counter_value}, 32'h0);
        for (s = 0; s < 4; s = s + 1) begin
            for (n = 0; n < 4; n = n + 1) begin
                v = (n << 4) | (s << 2);
                wr(`CLOCK_CONTROL_ADDR, v, r);
                base = counter_value;
                pulse(s, 3);
                chk({16'h0, counter_value}, {16'h0, base});
                wr(`CLOCK_CONTROL_ADDR, v | 32'h1, r);
                pulse((s + 1) % 4, 4);
                k = ($random(seed) & 7) + 1;
                pulse(s, k);
                repeat (2) @(posedge clk);
                chk({16'h0, counter_value}, exp_cnt(base, k, n));
            end
        end
        // reserved ratio code gives no tick
        wr(`CLOCK_CONTROL_ADDR, 32'hf1, r);
        base = counter_value;
        pulse(0, 4);
        chk({16'h0, counter_value}, {16'h0, base});
        wr(`CHANNEL_CONTROL_ADDR, 32'h0, r);
        wr(`CLOCK_CONTROL_ADDR, 32'h1, r);
        base = counter_value;
        pulse(0, 4);
        chk({16'h0, counter_value}, {16'h0, base});
        wr(`CHANNEL_CONTROL_ADDR, 32'h2, r);
        chk({16'h0, counter_value}, 32'h0);
        end_of_test;
    end

    // hang guard
    initial begin
        #400000;
        num_errors = num_errors + 1;
        end_of_test;
    end
endmodule // timer_clock_select_bench
